// ---- hdl/pos_pkg.sv ----
// Purpose: shared constants and types for shaft orientation and bias logic
// Assumes: 25 MHz clock, speeds in 0.01 Hz, gain in 0.01 rad/s
// Notes:   encoder counts are four per line (quadrature)
`default_nettype none
package pos_pkg;
    localparam int CLK_PERIOD_NS   = 40;
    localparam int CTRL_PERIOD_NS  = 2_000_000;
    localparam int CTRL_PERIOD_CYC = CTRL_PERIOD_NS / CLK_PERIOD_NS;
    localparam int DELAY_UNIT_NS   = 10_000_000;
    localparam int DELAY_UNIT_CYC  = DELAY_UNIT_NS / CLK_PERIOD_NS;
    localparam int LOOP_SHIFT      = 8;

    localparam int STOP_W = 12;
    localparam logic [15:0] PPR_MIN   = 16'h0080;
    localparam logic [15:0] PPR_MAX   = 16'hffff;
    localparam logic [15:0] SPEED_MAX = 16'h2ee0;
    localparam logic [15:0] WIN_MAX   = 16'h2710;
    localparam logic [15:0] GAIN_MAX  = 16'h2710;
    localparam logic [15:0] DELAY_MAX = 16'h03e7;

    localparam logic [1:0] DIR_FWD  = 2'h0;
    localparam logic [1:0] DIR_REV  = 2'h1;
    localparam logic       SIGN_SUB = 1'h1;

    typedef struct packed {
        logic [STOP_W-1:0] home_stop_point;
        logic [15:0]       home_search_speed;
        logic [1:0]        home_search_direction;
        logic [13:0]       home_done_window;
        logic [9:0]        home_done_delay;
        logic [13:0]       position_loop_gain;
        logic [15:0]       encoder_pulses_per_rev;
    } orient_cfg_s;

    typedef enum logic [1:0] {
        ST_IDLE     = 2'b00,
        ST_SEARCH   = 2'b01,
        ST_POSITION = 2'b11,
        ST_DONE     = 2'b10
    } home_state_e;
endpackage
`default_nettype wire

// ---- hdl/quad_counter.sv ----
// Purpose: quadrature position counter with index detection
// Assumes: encoder pins are asynchronous to clock_i
// Notes:   A leading B counts up; index is the positive leg high, negative low
`timescale 1ns/1ps
`default_nettype none
module quad_counter #(
    parameter int CNT_W = 32
) (
    input  wire logic                    clock_i,
    input  wire logic                    arst_n_i,
    input  wire logic                    enc_a_i,
    input  wire logic                    enc_b_i,
    input  wire logic                    index_pulse_positive_i,
    input  wire logic                    index_pulse_negative_i,
    output logic signed [CNT_W-1:0]      count_o,
    output logic                         index_o
);
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    logic [2:0] pin_last;

    wire a_now     = pin_sync[0];
    wire b_now     = pin_sync[1];
    wire index_now = pin_sync[2] & ~pin_sync[3];
    wire a_edge    = a_now ^ pin_last[0];
    wire b_edge    = b_now ^ pin_last[1];
    wire step      = a_edge ^ b_edge;
    wire step_up   = a_now ^ pin_last[1];

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_meta <= 4'h0;
            pin_sync <= 4'h0;
            pin_last <= 3'h0;
            count_o  <= '0;
            index_o  <= 1'b0;
        end else begin
            pin_meta <= {index_pulse_negative_i, index_pulse_positive_i,
                         enc_b_i, enc_a_i};
            pin_sync <= pin_meta;
            pin_last <= {index_now, b_now, a_now};
            index_o  <= index_now & ~pin_last[2];
            if (step) begin
                count_o <= step_up ? count_o + 1'b1 : count_o - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- hdl/shaft_orientation_and_bias.sv ----
// Purpose: position bias, speed bias and home search for a motor drive
// Assumes: at_speed_i comes from the speed ramp on the same clock
// Notes:   speed values in 0.01 Hz, position in quadrature counts
//
// Notes on behaviour
// - add position bias every 2 ms period in pulse mode
// - speed bias added only while terminal on
// - sign setting selects add or subtract
// - run with orientation on accelerates to search speed
// - running motor switches to search speed
// - at search speed, first index starts positioning
// - target one turn forward, two turns reverse
// - loop gain sets approach deceleration below the search speed cap
// - done after delay once inside window
// - done held until orientation input drops
// - servo lock holds until run removed
// - stop point is one of 4096 points
// - stop point scaled to encoder counts internally
// - index detection position is reference point
// - direction code 00 forward, 01 reverse
// - search speed limited to 120.00 Hz
// - completion window limited to 10000 pulses
// - encoder lines limited to 128..65535
// - loop gain limited to 100.00 rad/s
`timescale 1ns/1ps
`default_nettype none
module shaft_orientation_and_bias #(
    parameter int CTRL_PERIOD_CYCLES = pos_pkg::CTRL_PERIOD_CYC,
    parameter int DELAY_UNIT_CYCLES  = pos_pkg::DELAY_UNIT_CYC
) (
    input  wire logic                 clock_i,
    input  wire logic                 arst_n_i,
    input  wire logic                 pulse_mode_i,
    input  wire logic signed [15:0]   position_data_delta_i,
    input  wire logic signed [15:0]   position_bias_pulses_i,
    input  wire logic signed [16:0]   speed_command_i,
    input  wire logic [15:0]          speed_bias_frequency_i,
    input  wire logic                 speed_bias_sign_i,
    input  wire logic                 speed_bias_terminal_i,
    input  wire logic                 run_i,
    input  wire logic                 orientation_request_input_i,
    input  wire logic                 at_speed_i,
    input  wire pos_pkg::orient_cfg_s cfg_i,
    input  wire logic                 enc_a_i,
    input  wire logic                 enc_b_i,
    input  wire logic                 index_pulse_positive_i,
    input  wire logic                 index_pulse_negative_i,
    output logic signed [16:0]        position_step_o,
    output logic                      step_valid_o,
    output logic signed [17:0]        speed_ref_o,
    output logic                      position_mode_o,
    output logic                      positioning_done_output_o
);
    import pos_pkg::*;

    localparam int PW = $clog2(CTRL_PERIOD_CYCLES);
    localparam int UW = $clog2(DELAY_UNIT_CYCLES);
    localparam logic [PW-1:0] PERIOD_LAST = PW'(CTRL_PERIOD_CYCLES - 1);
    localparam logic [UW-1:0] UNIT_LAST   = UW'(DELAY_UNIT_CYCLES - 1);

    function automatic logic [15:0] clamp_u(input logic [15:0] v,
                                            input logic [15:0] lo,
                                            input logic [15:0] hi);
        if (v < lo) begin
            return lo;
        end else if (v > hi) begin
            return hi;
        end
        return v;
    endfunction

    function automatic logic [31:0] abs32(input logic signed [31:0] v);
        return v < 0 ? 32'(-v) : 32'(v);
    endfunction

    function automatic logic signed [17:0] sat18(
            input logic signed [47:0] v, input logic [15:0] lim);
        logic signed [47:0] lim_s;
        lim_s = $signed({32'h0, lim});
        if (v > lim_s) begin
            return $signed({2'b00, lim});
        end else if (v < -lim_s) begin
            return -$signed({2'b00, lim});
        end
        return v[17:0];
    endfunction

    // terminal inputs from pins
    logic [1:0] orient_sync;
    logic [1:0] add_sync;
    wire orient_on = orient_sync[1];
    wire add_on = add_sync[1];

    logic signed [31:0] enc_count;
    logic               index_seen;

    quad_counter #(.CNT_W(32)) i_quad_counter (
        .clock_i                (clock_i),
        .arst_n_i               (arst_n_i),
        .enc_a_i                (enc_a_i),
        .enc_b_i                (enc_b_i),
        .index_pulse_positive_i (index_pulse_positive_i),
        .index_pulse_negative_i (index_pulse_negative_i),
        .count_o                (enc_count),
        .index_o                (index_seen)
    );

    // settings held to their legal ranges
    wire [15:0] ppr_c   = clamp_u(cfg_i.encoder_pulses_per_rev,
                                  PPR_MIN, PPR_MAX);
    wire [15:0] speed_c = clamp_u(cfg_i.home_search_speed,
                                  16'h0000, SPEED_MAX);
    wire [15:0] win_c   = clamp_u({2'b00, cfg_i.home_done_window},
                                  16'h0000, WIN_MAX);
    wire [15:0] gain_c  = clamp_u({2'b00, cfg_i.position_loop_gain},
                                  16'h0000, GAIN_MAX);
    wire [15:0] delay_c = clamp_u({6'h00, cfg_i.home_done_delay},
                                  16'h0000, DELAY_MAX);

    // stop point scaled from 1/4096 turn to counts
    wire [17:0] cpr        = {ppr_c, 2'b00};
    wire [29:0] stop_prod  = cfg_i.home_stop_point * cpr;
    wire [17:0] stop_cnts  = stop_prod[29:STOP_W];
    wire        dir_rev    = cfg_i.home_search_direction == DIR_REV;
    wire signed [31:0] fwd_offset = $signed({14'h0, stop_cnts})
                                  + $signed({14'h0, cpr});
    wire signed [31:0] rev_offset = $signed({14'h0, stop_cnts})
                                  - $signed({13'h0, cpr, 1'b0});

    home_state_e        state;
    home_state_e        next_state;
    logic signed [31:0] target;
    logic [PW-1:0]      period_cnt;
    logic [UW-1:0]      unit_cnt;
    logic [9:0]         delay_cnt;

    // control period divider
    wire period_tick = period_cnt == PERIOD_LAST;

    // position loop: speed proportional to remaining counts
    wire signed [31:0] deviation = target - enc_count;
    wire signed [47:0] loop_prod = 48'(deviation)
                                 * $signed({32'h0, gain_c});
    wire signed [47:0] loop_scaled = loop_prod >>> LOOP_SHIFT;
    wire signed [17:0] loop_speed = sat18(loop_scaled, speed_c);

    wire in_window  = abs32(deviation) <= {16'h0, win_c};
    wire pos_window = state == ST_POSITION && in_window;
    wire unit_tick  = unit_cnt == UNIT_LAST;
    wire elapsed    = pos_window && {6'h00, delay_cnt} >= delay_c;
    wire lock_now   = at_speed_i && index_seen;

    wire signed [16:0] next_step = {position_data_delta_i[15],
                                    position_data_delta_i}
                                 + (pulse_mode_i
                                    ? {position_bias_pulses_i[15],
                                       position_bias_pulses_i}
                                    : 17'h00000);

    wire signed [17:0] bias_val = speed_bias_sign_i == SIGN_SUB
                                ? -$signed({2'b00, speed_bias_frequency_i})
                                : $signed({2'b00, speed_bias_frequency_i});
    wire signed [17:0] search_val = dir_rev ? -$signed({2'b00, speed_c})
                                            : $signed({2'b00, speed_c});
    wire signed [17:0] idle_val = {speed_command_i[16], speed_command_i}
                                + (add_on ? bias_val : 18'h00000);

    logic signed [17:0] next_speed;
    always_comb begin
        unique case (state)
            ST_IDLE:   next_speed = idle_val;
            ST_SEARCH: next_speed = search_val;
            default:   next_speed = loop_speed;
        endcase
    end

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (run_i && orient_on) begin
                    next_state = ST_SEARCH;
                end
            end
            ST_SEARCH: begin
                if (!run_i || !orient_on) begin
                    next_state = ST_IDLE;
                end else if (lock_now) begin
                    next_state = ST_POSITION;
                end
            end
            ST_POSITION: begin
                if (!run_i) begin
                    next_state = ST_IDLE;
                end else if (elapsed) begin
                    next_state = ST_DONE;
                end
            end
            ST_DONE: begin
                if (!run_i) begin
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    wire next_done = elapsed || (positioning_done_output_o && orient_on);

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            orient_sync <= 2'h0;
            add_sync <= 2'h0;
            period_cnt <= '0;
            step_valid_o <= 1'b0;
            position_step_o <= '0;
        end else begin
            orient_sync <= {orient_sync[0], orientation_request_input_i};
            add_sync <= {add_sync[0], speed_bias_terminal_i};
            period_cnt <= period_tick ? '0 : period_cnt + 1'b1;
            step_valid_o <= period_tick;
            if (period_tick) begin
                position_step_o <= next_step;
            end
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= ST_IDLE;
            target <= '0;
            speed_ref_o <= '0;
            positioning_done_output_o <= 1'b0;
        end else begin
            state <= next_state;
            speed_ref_o <= next_speed;
            positioning_done_output_o <= next_done;
            if (state == ST_SEARCH && lock_now) begin
                // reference is the count at the index edge
                target <= enc_count + (dir_rev ? rev_offset
                                               : fwd_offset);
            end
        end
    end

    // completion delay counted in 0.01 s units from window entry
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            unit_cnt <= '0;
            delay_cnt <= '0;
        end else if (!pos_window) begin
            unit_cnt <= '0;
            delay_cnt <= '0;
        end else begin
            unit_cnt <= unit_tick ? '0 : unit_cnt + 1'b1;
            if (unit_tick && delay_cnt != 10'h3ff) begin
                delay_cnt <= delay_cnt + 1'b1;
            end
        end
    end

    assign position_mode_o = state == ST_POSITION || state == ST_DONE;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);

    AST_BIAS_STEP: assert property (period_tick && pulse_mode_i |=>
        step_valid_o && position_step_o ==
        $past(position_data_delta_i) + $past(position_bias_pulses_i))
        else $error("bias not added in period");
    AST_BIAS_OFF: assert property (period_tick && !pulse_mode_i |=>
        position_step_o == $past(position_data_delta_i))
        else $error("bias applied outside pulse mode");
    AST_STEP_RATE: assert property (step_valid_o |->
        ##1 !step_valid_o [*8])
        else $error("position step too frequent");
    AST_ADD_ON: assert property (state == ST_IDLE && add_on
        && speed_bias_sign_i != SIGN_SUB |=> speed_ref_o ==
        $past(speed_command_i) + $signed({2'b00,
                                  $past(speed_bias_frequency_i)}))
        else $error("speed bias not added");
    AST_ADD_OFF: assert property (state == ST_IDLE && !add_on
        |=> speed_ref_o == $past(speed_command_i))
        else $error("speed bias leaked while terminal off");
    AST_ADD_SUB: assert property (state == ST_IDLE && add_on
        && speed_bias_sign_i == SIGN_SUB |=> speed_ref_o ==
        $past(speed_command_i) - $signed({2'b00,
                                  $past(speed_bias_frequency_i)}))
        else $error("speed bias sign wrong");
    AST_START: assert property (state == ST_IDLE && run_i
        && orient_on |=> state == ST_SEARCH
        ##1 speed_ref_o == $past(search_val))
        else $error("home search not started");
    AST_SEARCH_SPD: assert property (state == ST_SEARCH && !dir_rev
        |=> speed_ref_o == $signed({2'b00, $past(speed_c)}))
        else $error("search speed wrong");
    AST_LOCK: assert property (state == ST_SEARCH && run_i
        && orient_on && at_speed_i && index_seen |=> state == ST_POSITION)
        else $error("index did not start positioning");
    AST_NO_EARLY: assert property (state == ST_SEARCH && !at_speed_i
        |=> state != ST_POSITION)
        else $error("positioning before search speed");
    AST_TARGET: assert property ($past(state) == ST_SEARCH
        && state == ST_POSITION |-> target == $past(enc_count)
        + ($past(dir_rev) ? $signed({14'h0, $past(stop_cnts)})
                            - 2 * $signed({14'h0, $past(cpr)})
                          : $signed({14'h0, $past(stop_cnts)})
                            + $signed({14'h0, $past(cpr)})))
        else $error("positioning target wrong");
    AST_LOOP_DIR: assert property (state == ST_POSITION
        && deviation > 0 && gain_c != 16'h0000 && speed_c != 16'h0000
        |=> speed_ref_o >= 0)
        else $error("loop drives away from target");
    AST_STOP_RANGE: assert property (stop_cnts < cpr)
        else $error("stop point beyond one turn");
    AST_DONE_SET: assert property ($rose(positioning_done_output_o)
        |-> $past(elapsed))
        else $error("done without elapsed delay");
    AST_DONE_HOLD: assert property (positioning_done_output_o
        && orient_on |=> positioning_done_output_o)
        else $error("done dropped while orientation on");
    AST_SERVO: assert property (state == ST_DONE && run_i
        |=> state == ST_DONE)
        else $error("servo lock released with run on");
endmodule
`default_nettype wire

// ---- tb/enc_model.sv ----
// Purpose: behavioural motor shaft with quadrature encoder and index pair
// Assumes: shaft steps one count every STEP cycles in the sign of speed_i
// Notes:   index sits at every multiple of CPR counts
`timescale 1ns/1ps
`default_nettype none
module enc_model #(
    parameter int CPR  = 512,
    parameter int STEP = 4
) (
    input  wire logic               clock_i,
    input  wire logic signed [17:0] speed_i,
    output logic                    enc_a_o,
    output logic                    enc_b_o,
    output logic                    idx_p_o,
    output logic                    idx_n_o
);
    int pos = 0;
    int div = 0;
    wire logic [1:0] ph;
    wire logic       at_ref;

    assign ph = 2'(pos & 3);
    // a leads b when counting up
    assign enc_a_o = (ph == 2'h1) || (ph == 2'h2);
    assign enc_b_o = (ph == 2'h2) || (ph == 2'h3);
    assign at_ref  = (((pos % CPR) + CPR) % CPR) == 0;
    // index is positive leg high with negative leg low
    assign idx_p_o = at_ref;
    assign idx_n_o = !at_ref;

    always @(posedge clock_i) begin
        div <= (div == STEP - 1) ? 0 : div + 1;
        if (div == STEP - 1 && speed_i > 0) begin
            pos <= pos + 1;
        end
        if (div == STEP - 1 && speed_i < 0) begin
            pos <= pos - 1;
        end
    end
endmodule
`default_nettype wire

// ---- tb/tb_shaft_orientation_and_bias.sv ----
// Purpose: self-checking bench for shaft orientation and bias logic
// Assumes: short period (16) and delay unit (8) parameters, 128 lines
// Notes:   shaft model follows the sign of the speed reference
`timescale 1ns/1ps
`default_nettype none
module tb_shaft_orientation_and_bias;
    import pos_pkg::*;
    logic               clock_i = 1'b0;
    logic               arst_n  = 1'b0;
    logic               pulse_mode = 1'b0;
    logic signed [15:0] delta = 16'sh0;
    logic signed [15:0] bias  = 16'sh0;
    logic signed [16:0] cmd   = 17'sh0;
    logic [15:0]        freq  = 16'h0;
    logic               sign  = 1'b0;
    logic               term  = 1'b0;
    logic               run   = 1'b0;
    logic               orient = 1'b0;
    logic               at_speed = 1'b0;
    orient_cfg_s        cfg;
    logic               ea, eb, ip, in_n;
    logic signed [16:0] position_step_o;
    logic               step_valid_o, position_mode_o, done;
    logic signed [17:0] speed_ref_o;
    int err_count = 0;
    int checked   = 0;
    int waited;

    always #20 clock_i = ~clock_i;

    shaft_orientation_and_bias #(
        .CTRL_PERIOD_CYCLES(16),
        .DELAY_UNIT_CYCLES (8)
    ) i_shaft_orientation_and_bias (
        .clock_i(clock_i), .arst_n_i(arst_n), .pulse_mode_i(pulse_mode),
        .position_data_delta_i(delta), .position_bias_pulses_i(bias),
        .speed_command_i(cmd), .speed_bias_frequency_i(freq),
        .speed_bias_sign_i(sign), .speed_bias_terminal_i(term),
        .run_i(run), .orientation_request_input_i(orient),
        .at_speed_i(at_speed), .cfg_i(cfg), .enc_a_i(ea), .enc_b_i(eb),
        .index_pulse_positive_i(ip), .index_pulse_negative_i(in_n),
        .position_step_o(position_step_o), .step_valid_o(step_valid_o),
        .speed_ref_o(speed_ref_o), .position_mode_o(position_mode_o),
        .positioning_done_output_o(done)
    );

    enc_model #(.CPR(512), .STEP(4)) i_enc_model (
        .clock_i(clock_i), .speed_i(speed_ref_o), .enc_a_o(ea),
        .enc_b_o(eb), .idx_p_o(ip), .idx_n_o(in_n)
    );

    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wait_valid();
        waited = 0;
        while (step_valid_o !== 1'b1 && waited < 100) begin
            tick(1);
            waited++;
        end
    endtask

    task automatic t_period();
        pulse_mode = 1'b1;
        delta = 16'sh5;
        bias  = -16'sh3;
        wait_valid();
        tick(1);
        wait_valid();
        chk(position_step_o, 2);
        tick(1);
        chk(step_valid_o, 0);
        wait_valid();
        chk(waited, 15);
        pulse_mode = 1'b0;
        tick(1);
        wait_valid();
        tick(1);
        wait_valid();
        chk(position_step_o, 5);
        $display("test period finished");
    endtask

    task automatic t_speed_bias();
        cmd  = 17'sh3e8;
        freq = 16'h00fa;
        term = 1'b1;
        tick(5);
        chk(speed_ref_o, 1250);
        sign = SIGN_SUB;
        tick(3);
        chk(speed_ref_o, 750);
        term = 1'b0;
        tick(5);
        chk(speed_ref_o, 1000);
        cmd  = 17'sh0;
        tick(2);
        $display("test speed bias finished");
    endtask

    task automatic t_home(input logic [1:0] dir, input bit pre_run);
        int p0;
        int m;
        cfg.home_search_direction = dir;
        cmd = 17'sh12c;
        if (pre_run) begin
            run = 1'b1;
            tick(5);
            chk(speed_ref_o, 300);
        end
        orient = 1'b1;
        tick(1);
        run = 1'b1;
        tick(6);
        m = (dir == DIR_REV) ? -1000 : 1000;
        chk(speed_ref_o, m);
        tick(3000);
        chk(position_mode_o, 0);
        at_speed = 1'b1;
        waited = 0;
        while (position_mode_o !== 1'b1 && waited < 4000) begin
            tick(1);
            waited++;
        end
        chk(position_mode_o, 1);
        p0 = i_enc_model.pos;
        at_speed = 1'b0;
        waited = 0;
        while (done !== 1'b1 && waited < 8000) begin
            tick(1);
            waited++;
        end
        chk(done, 1);
        m = ((i_enc_model.pos % 512) + 512) % 512 - 256;
        chk(m > -20 && m < 20, 1);
        m = i_enc_model.pos - p0;
        if (dir == DIR_REV) begin
            chk(m > -900 && m < -600, 1);
        end else begin
            chk(m > 600 && m < 900, 1);
        end
        tick(50);
        chk(done, 1);
        orient = 1'b0;
        tick(4);
        chk(done, 0);
        chk(position_mode_o, 1);
        run = 1'b0;
        cmd = 17'sh0;
        tick(2);
        chk(position_mode_o, 0);
        tick(5);
        $display("test home search finished");
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        // low search speed keeps the approach short
        cfg.home_stop_point        = 12'h800;
        cfg.home_search_speed      = 16'h03e8;
        cfg.home_search_direction  = DIR_FWD;
        cfg.home_done_window       = 14'h0014;
        cfg.home_done_delay        = 10'h001;
        cfg.position_loop_gain     = 14'h2710;
        cfg.encoder_pulses_per_rev = 16'h0080;
        tick(8);
        arst_n = 1'b1;
        tick(1);
        t_period();
        t_speed_bias();
        t_home(DIR_FWD, 1'b0);
        t_home(DIR_REV, 1'b1);
        conclude();
    end

    initial begin
        #(40 * 60000);
        err_count++;
        conclude();
    end
endmodule
`default_nettype wire
